// ---- shared/sdce_pkg.sv ----
// Constants shared by the step detect and count engine
package sdce_pkg;

   // Register offsets on the plain register port
   localparam logic [7:0] SDCE_OFS_CTRL = 8'h00;
   localparam logic [7:0] SDCE_OFS_DEBOUNCE = 8'h01;
   localparam logic [7:0] SDCE_OFS_DELTA_LO = 8'h02;
   localparam logic [7:0] SDCE_OFS_DELTA_HI = 8'h03;
   localparam logic [7:0] SDCE_OFS_ROUTE = 8'h04;
   localparam logic [7:0] SDCE_OFS_SOURCE = 8'h05;
   localparam logic [7:0] SDCE_OFS_COUNT_LO = 8'h06;
   localparam logic [7:0] SDCE_OFS_COUNT_HI = 8'h07;
   localparam logic [7:0] SDCE_OFS_STATUS = 8'h08;
   localparam logic [7:0] SDCE_OFS_MIRROR = 8'h09;

   // Control register fields
   localparam int SDCE_CTRL_ENGINE_ON = 0;
   localparam int SDCE_CTRL_REINIT = 1;
   localparam int SDCE_CTRL_GATE_ON = 2;
   localparam int SDCE_CTRL_CLASSIFIER_ON = 3;
   localparam int SDCE_CTRL_CLASSIFIER_FIRST = 4;
   localparam int SDCE_CTRL_CARRY = 5;
   localparam int SDCE_CTRL_LATCH = 6;
   localparam int SDCE_CTRL_TIMESTAMP_ON = 7;

   // Routing register fields
   localparam int SDCE_RT_STRIDE_PIN1 = 0;
   localparam int SDCE_RT_STRIDE_PIN2 = 1;
   localparam int SDCE_RT_EMB_PIN1 = 2;
   localparam int SDCE_RT_EMB_PIN2 = 3;
   localparam int SDCE_RT_BATCH = 4;

   // Event source register fields
   localparam int SDCE_SRC_CLEAR = 7;
   localparam int SDCE_SRC_SEEN = 5;
   localparam int SDCE_SRC_DELTA = 4;
   localparam int SDCE_SRC_OVERFLOW = 3;
   localparam int SDCE_SRC_INCR = 2;

   // Values after reset, and the largest count
   localparam logic [7:0] SDCE_RST_CTRL = 8'h00;
   localparam logic [7:0] SDCE_RST_DEBOUNCE = 8'h0A;
   localparam logic [15:0] SDCE_RST_DELTA = 16'h0000;
   localparam logic [4:0] SDCE_RST_ROUTE = 5'h00;
   localparam logic [15:0] SDCE_RST_COUNT = 16'h0000;
   localparam logic [15:0] SDCE_COUNT_MAX = 16'hFFFF;

   // Classifier codes of the first decision tree
   localparam logic [7:0] SDCE_CLASS_NO_WALK = 8'h04;
   localparam logic [7:0] SDCE_CLASS_WALK = 8'h08;
   localparam logic [7:0] SDCE_INHIB_A_LO = 8'h04;
   localparam logic [7:0] SDCE_INHIB_A_HI = 8'h07;
   localparam logic [7:0] SDCE_INHIB_B_LO = 8'h0C;
   localparam logic [7:0] SDCE_INHIB_B_HI = 8'h0E;

   // Timing
   localparam int SDCE_CLK_HZ = 25_000_000;
   localparam int SDCE_RATE_HZ = 30;
   localparam int SDCE_TICK_CYC = SDCE_CLK_HZ / SDCE_RATE_HZ;
   localparam int SDCE_DELTA_LSB_US = 5600;
   localparam int SDCE_DELTA_CYC = (SDCE_CLK_HZ / 1_000_000) * SDCE_DELTA_LSB_US;
   localparam int SDCE_IDLE_MS = 1000;
   localparam int SDCE_IDLE_TICKS = (SDCE_IDLE_MS * SDCE_RATE_HZ) / 1000;

   // Debounce states
   typedef enum logic [0:0] {
      SDCE_ARMING,
      SDCE_COUNTING
   } sdce_deb_t;

endpackage : sdce_pkg

// ---- verilog/sdce_engine.sv ----
// Step detect and count engine with register port and interrupt pins
//
// The strobed register port and the register addresses are this design's own decisions.
module sdce_engine #(
   parameter int TICK_CYC = sdce_pkg::SDCE_TICK_CYC,
   parameter int DELTA_CYC = sdce_pkg::SDCE_DELTA_CYC
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic step_raw,
   input wire logic [7:0] class_code,
   output logic int1,
   output logic int2,
   output logic batch_valid,
   output logic [15:0] batch_data
);

   localparam int TW = $clog2(TICK_CYC + 1);
   localparam int DW = $clog2(DELTA_CYC + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
   localparam logic [TW-1:0] PULSE_LEN = TW'(TICK_CYC);
   localparam logic [DW-1:0] DELTA_LAST = DW'(DELTA_CYC - 1);
   localparam logic [5:0] IDLE_LAST = 6'(sdce_pkg::SDCE_IDLE_TICKS - 1);

   logic [7:0] ctrl_ff;
   logic [7:0] deb_cfg_ff;
   logic [15:0] delta_ff;
   logic [4:0] route_ff;
   logic clr_pend_ff;
   logic [15:0] count_ff;
   logic [TW-1:0] tick_cnt_ff;
   logic tick_ff;
   logic [5:0] idle_ff;
   sdce_pkg::sdce_deb_t deb_state_ff;
   logic [7:0] seen_ff;
   logic [DW-1:0] lsb_cnt_ff;
   logic [15:0] win_ticks_ff;
   logic win_steps_ff;
   logic seen_flag_ff;
   logic delta_flag_ff;
   logic ovf_flag_ff;
   logic inc_flag_ff;
   logic status_ff;
   logic [TW-1:0] hold_ff;
   logic [7:0] rdata_ff;
   logic int1_ff;
   logic int2_ff;
   logic batch_valid_ff;
   logic [15:0] batch_data_ff;

   // Decoded strobes
   logic wr_ctrl;
   logic reinit;
   logic src_rd;
   logic status_rd;
   assign wr_ctrl = reg_wr && (reg_addr == sdce_pkg::SDCE_OFS_CTRL);
   assign reinit = wr_ctrl && reg_wdata[sdce_pkg::SDCE_CTRL_REINIT];
   assign src_rd = reg_rd && (reg_addr == sdce_pkg::SDCE_OFS_SOURCE);
   assign status_rd = reg_rd && ((reg_addr == sdce_pkg::SDCE_OFS_STATUS) ||
      (reg_addr == sdce_pkg::SDCE_OFS_MIRROR));

   logic engine_on;
   logic gate_block;
   logic class_inhib;
   logic step_ok;
   logic deb_done;
   logic counted;
   logic ovf_evt;
   logic win_on;
   logic win_end;
   logic irq_evt;
   assign engine_on = ctrl_ff[sdce_pkg::SDCE_CTRL_ENGINE_ON];

   // codes four to seven and twelve to fourteen inhibit; code eight passes
   assign class_inhib = ((class_code >= sdce_pkg::SDCE_INHIB_A_LO) &&
      (class_code <= sdce_pkg::SDCE_INHIB_A_HI)) ||
      ((class_code >= sdce_pkg::SDCE_INHIB_B_LO) &&
      (class_code <= sdce_pkg::SDCE_INHIB_B_HI));
   // gate needs its bit and a classifier bit
   assign gate_block = ctrl_ff[sdce_pkg::SDCE_CTRL_GATE_ON] &&
      (ctrl_ff[sdce_pkg::SDCE_CTRL_CLASSIFIER_ON] ||
      ctrl_ff[sdce_pkg::SDCE_CTRL_CLASSIFIER_FIRST]) && class_inhib;
   assign step_ok = step_raw && engine_on && !gate_block;
   // the step reaching the debounce figure counts
   assign deb_done = (deb_state_ff == sdce_pkg::SDCE_COUNTING) ||
      ({1'b0, seen_ff} + 9'h001 >= {1'b0, deb_cfg_ff});
   assign counted = step_ok && deb_done && !clr_pend_ff;
   assign ovf_evt = counted && (count_ff == sdce_pkg::SDCE_COUNT_MAX);
   // window runs only with the timestamp timer on
   assign win_on = engine_on && (delta_ff != 16'h0000) &&
      ctrl_ff[sdce_pkg::SDCE_CTRL_TIMESTAMP_ON];
   assign win_end = win_on && (lsb_cnt_ff == DELTA_LAST) &&
      (win_ticks_ff + 16'h0001 >= delta_ff);

   // source select for the interrupt status
   always_comb begin
      if (ctrl_ff[sdce_pkg::SDCE_CTRL_CARRY]) begin
         irq_evt = ovf_evt;
      end else if (delta_ff == 16'h0000) begin
         irq_evt = counted;
      end else begin
         irq_evt = win_end && (win_steps_ff || counted);
      end
   end

   // Configuration writes; reinit is never stored so it reads zero
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff <= sdce_pkg::SDCE_RST_CTRL;
         deb_cfg_ff <= sdce_pkg::SDCE_RST_DEBOUNCE;
         delta_ff <= sdce_pkg::SDCE_RST_DELTA;
         route_ff <= sdce_pkg::SDCE_RST_ROUTE;
      end else if (reg_wr) begin
         case (reg_addr)
            sdce_pkg::SDCE_OFS_CTRL: ctrl_ff <= reg_wdata & 8'hFD;
            sdce_pkg::SDCE_OFS_DEBOUNCE: deb_cfg_ff <= reg_wdata;
            sdce_pkg::SDCE_OFS_DELTA_LO: delta_ff[7:0] <= reg_wdata;
            sdce_pkg::SDCE_OFS_DELTA_HI: delta_ff[15:8] <= reg_wdata;
            sdce_pkg::SDCE_OFS_ROUTE: route_ff <= reg_wdata[4:0];
            default: ;
         endcase
      end
   end

   // sample rate tick paces idle time; pulse length is one tick period counted per clock in hold_ff
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else if (tick_cnt_ff == TICK_LAST) begin
         tick_cnt_ff <= '0;
         tick_ff <= 1'b1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + TW'(1);
         tick_ff <= 1'b0;
      end
   end

   // Debounce session tracking
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         deb_state_ff <= sdce_pkg::SDCE_ARMING;
         seen_ff <= 8'h00;
         idle_ff <= 6'h00;
      end else if (reinit || !engine_on) begin
         deb_state_ff <= sdce_pkg::SDCE_ARMING;
         seen_ff <= 8'h00;
         idle_ff <= 6'h00;
      end else if (step_ok) begin
         idle_ff <= 6'h00;
         if (deb_done) begin
            deb_state_ff <= sdce_pkg::SDCE_COUNTING;
         end else begin
            seen_ff <= seen_ff + 8'h01;
         end
      end else if (tick_ff) begin
         // idle for a second rearms debounce
         if (idle_ff == IDLE_LAST) begin
            deb_state_ff <= sdce_pkg::SDCE_ARMING;
            seen_ff <= 8'h00;
            idle_ff <= 6'h00;
         end else begin
            idle_ff <= idle_ff + 6'h01;
         end
      end
   end

   // clear request held one cycle, then bit drops itself
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         clr_pend_ff <= 1'b0;
      end else begin
         clr_pend_ff <= reg_wr && (reg_addr == sdce_pkg::SDCE_OFS_SOURCE) &&
            reg_wdata[sdce_pkg::SDCE_SRC_CLEAR];
      end
   end

   // sixteen bit count; kept through disable and reinit
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         count_ff <= sdce_pkg::SDCE_RST_COUNT;
      end else if (clr_pend_ff) begin
         count_ff <= sdce_pkg::SDCE_RST_COUNT;
      end else if (counted) begin
         count_ff <= count_ff + 16'h0001;
      end
   end

   // Delta window timer, one lsb every 5.6 ms
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         lsb_cnt_ff <= '0;
         win_ticks_ff <= 16'h0000;
         win_steps_ff <= 1'b0;
      end else if (!win_on || reinit) begin
         lsb_cnt_ff <= '0;
         win_ticks_ff <= 16'h0000;
         win_steps_ff <= 1'b0;
      end else if (win_end) begin
         lsb_cnt_ff <= '0;
         win_ticks_ff <= 16'h0000;
         win_steps_ff <= 1'b0;
      end else begin
         if (lsb_cnt_ff == DELTA_LAST) begin
            lsb_cnt_ff <= '0;
            win_ticks_ff <= win_ticks_ff + 16'h0001;
         end else begin
            lsb_cnt_ff <= lsb_cnt_ff + DW'(1);
         end
         if (counted) begin
            win_steps_ff <= 1'b1;
         end
      end
   end

   // Source flags: sticky, cleared by reading the source register; set wins
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         seen_flag_ff <= 1'b0;
         delta_flag_ff <= 1'b0;
         ovf_flag_ff <= 1'b0;
         inc_flag_ff <= 1'b0;
      end else begin
         if (counted) begin
            seen_flag_ff <= 1'b1;
         end else if (src_rd) begin
            seen_flag_ff <= 1'b0;
         end
         // set at window end, held zero with no period
         if (delta_ff == 16'h0000) begin
            delta_flag_ff <= 1'b0;
         end else if (win_end && (win_steps_ff || counted)) begin
            delta_flag_ff <= 1'b1;
         end else if (src_rd) begin
            delta_flag_ff <= 1'b0;
         end
         if (ovf_evt) begin
            ovf_flag_ff <= 1'b1;
         end else if (src_rd) begin
            ovf_flag_ff <= 1'b0;
         end
         // increment flag, forced zero with a window set
         if (delta_ff != 16'h0000) begin
            inc_flag_ff <= 1'b0;
         end else if (counted) begin
            inc_flag_ff <= 1'b1;
         end else if (src_rd) begin
            inc_flag_ff <= 1'b0;
         end
      end
   end

   // interrupt status on each selected event
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         status_ff <= 1'b0;
         hold_ff <= '0;
      end else if (irq_evt) begin
         status_ff <= 1'b1;
         hold_ff <= PULSE_LEN;
      end else if (ctrl_ff[sdce_pkg::SDCE_CTRL_LATCH]) begin
         hold_ff <= '0;
         if (status_rd) begin
            status_ff <= 1'b0;
         end
      end else if (hold_ff > TW'(1)) begin
         hold_ff <= hold_ff - TW'(1);
      end else begin
         status_ff <= 1'b0;
         hold_ff <= '0;
      end
   end

   // both routing bits needed per pin
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         int1_ff <= 1'b0;
         int2_ff <= 1'b0;
      end else begin
         int1_ff <= status_ff && route_ff[sdce_pkg::SDCE_RT_STRIDE_PIN1] &&
            route_ff[sdce_pkg::SDCE_RT_EMB_PIN1];
         int2_ff <= status_ff && route_ff[sdce_pkg::SDCE_RT_STRIDE_PIN2] &&
            route_ff[sdce_pkg::SDCE_RT_EMB_PIN2];
      end
   end

   // new count handed to the sample buffer
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         batch_valid_ff <= 1'b0;
         batch_data_ff <= 16'h0000;
      end else begin
         batch_valid_ff <= counted && route_ff[sdce_pkg::SDCE_RT_BATCH];
         if (counted) begin
            batch_data_ff <= count_ff + 16'h0001;
         end
      end
   end

   // Read data valid only in the cycle after the strobe
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (reg_addr)
         sdce_pkg::SDCE_OFS_CTRL: rd_mux = ctrl_ff;
         sdce_pkg::SDCE_OFS_DEBOUNCE: rd_mux = deb_cfg_ff;
         sdce_pkg::SDCE_OFS_DELTA_LO: rd_mux = delta_ff[7:0];
         sdce_pkg::SDCE_OFS_DELTA_HI: rd_mux = delta_ff[15:8];
         sdce_pkg::SDCE_OFS_ROUTE: rd_mux = {3'h0, route_ff};
         sdce_pkg::SDCE_OFS_SOURCE: rd_mux = {clr_pend_ff, 1'b0, seen_flag_ff,
            delta_flag_ff, ovf_flag_ff, inc_flag_ff, 2'h0};
         sdce_pkg::SDCE_OFS_COUNT_LO: rd_mux = count_ff[7:0];
         sdce_pkg::SDCE_OFS_COUNT_HI: rd_mux = count_ff[15:8];
         sdce_pkg::SDCE_OFS_STATUS: rd_mux = {7'h00, status_ff};
         sdce_pkg::SDCE_OFS_MIRROR: rd_mux = {7'h00, status_ff};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= reg_rd ? rd_mux : 8'h00;
      end
   end

   assign reg_rdata = rdata_ff;
   assign int1 = int1_ff;
   assign int2 = int2_ff;
   assign batch_valid = batch_valid_ff;
   assign batch_data = batch_data_ff;

   // Checks on the engine behaviour
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   a_count_kept: assert property (!engine_on && !clr_pend_ff |=>
      count_ff == $past(count_ff))
      else $error("count moved while engine off");
   // A second clear write right behind the first legally keeps the bit up
   a_clear_zero: assert property (clr_pend_ff && !(reg_wr &&
      reg_addr == sdce_pkg::SDCE_OFS_SOURCE && reg_wdata[sdce_pkg::SDCE_SRC_CLEAR]) |=>
      count_ff == 16'h0000 && !clr_pend_ff)
      else $error("count clear failed");
   // A reinit in the same cycle restarts the debounce instead
   a_debounce_hold: assert property (step_ok && !deb_done && !clr_pend_ff && !reinit |=>
      count_ff == $past(count_ff) && seen_ff == $past(seen_ff) + 8'h01)
      else $error("step counted before debounce");
   a_idle_rearm: assert property (engine_on && !reinit && !step_ok && tick_ff &&
      idle_ff == IDLE_LAST |=> deb_state_ff == sdce_pkg::SDCE_ARMING && seen_ff == 8'h00)
      else $error("debounce not rearmed after idle");
   a_gate_stops: assert property (gate_block && !clr_pend_ff |=>
      $stable(count_ff))
      else $error("gated step was counted");
   a_delta_zero: assert property (delta_ff == 16'h0000 |=> !delta_flag_ff)
      else $error("window flag set with no period");
   a_inc_zero: assert property (delta_ff != 16'h0000 |=> !inc_flag_ff)
      else $error("increment flag set with window");
   a_overflow_wrap: assert property (ovf_evt |=> ovf_flag_ff &&
      count_ff == 16'h0000)
      else $error("overflow not flagged");
   a_pulse_width: assert property (irq_evt && !ctrl_ff[sdce_pkg::SDCE_CTRL_LATCH]
      ##1 !ctrl_ff[sdce_pkg::SDCE_CTRL_LATCH] [*7] |-> status_ff [*1])
      else $error("pulse ended early");
   a_latch_hold: assert property (ctrl_ff[sdce_pkg::SDCE_CTRL_LATCH] && status_ff &&
      !status_rd |=> status_ff)
      else $error("latched status dropped without read");
   a_pin_gate: assert property (status_ff && !route_ff[sdce_pkg::SDCE_RT_EMB_PIN1]
      |=> !int1_ff)
      else $error("pin one driven without common routing");

   c_first_count: cover property (deb_state_ff == sdce_pkg::SDCE_ARMING ##1
      deb_state_ff == sdce_pkg::SDCE_COUNTING);
   c_window_flag: cover property (win_end && win_steps_ff);
   c_latched_read: cover property (status_ff && status_rd);
   c_overflow: cover property (ovf_evt);

endmodule : sdce_engine

// ---- tb/sdce_host_model.sv ----
// Host software model driving the engine register port
module sdce_host_model (
   input wire logic core_clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // One-cycle write; idle lines flip so a stale value never looks valid
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge core_clk);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~addr;
      reg_wdata <= ~data;
   endtask : wr

   // One-cycle read; data taken in the single cycle it stands
   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(posedge core_clk);
      reg_addr <= addr;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~addr;
      @(posedge core_clk);
      data = reg_rdata;
   endtask : rd

   // timer with window
   // Period goes in first so a timer switched on by the control write never runs on a half-written value
   task automatic window(input logic [15:0] period, input logic [7:0] ctrl);
      wr(8'h02, period[7:0]);
      wr(8'h03, period[15:8]);
      wr(8'h00, ctrl);
   endtask : window
endmodule : sdce_host_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the step detect and count engine
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int TICK = 20;
   localparam int DCYC = 4;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic [7:0] exp;
   } sdce_row_t;

   logic core_clk, rstn, reg_wr, reg_rd, step_raw, int1, int2, batch_valid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, class_code, rdv;
   logic [15:0] batch_data, cnt;
   int miscompares, n_compared, run1, last_run1;
   sdce_row_t rows [16];
   logic [7:0] codes [11];

   sdce_engine #(.TICK_CYC(TICK), .DELTA_CYC(DCYC)) u_dut (.core_clk(core_clk), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .step_raw(step_raw), .class_code(class_code), .int1(int1),
      .int2(int2), .batch_valid(batch_valid), .batch_data(batch_data));

   sdce_host_model u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   // Free-running core clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // Length of the last int1 pulse; a stuck pin shows up as a wrong length
   always @(posedge core_clk) begin
      if (int1 === 1'b1) begin
         run1 <= run1 + 1;
      end else if (run1 != 0) begin
         last_run1 <= run1;
         run1 <= 0;
      end
   end

   task automatic final_report();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   // Hang guard
   initial begin
      repeat (90000) @(posedge core_clk);
      miscompares++;
      final_report();
   end

   task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(addr, d);
      chk_val($sformatf("reg %h", addr), {8'h00, exp}, {8'h00, d});
   endtask : rd_chk

   // paced steps
   // One step pulse; a counted step must reach the buffer with the new count
   task automatic step(input logic counted);
      logic seen;
      logic [15:0] data;
      seen = 1'b0;
      data = 16'h0000;
      @(posedge core_clk);
      step_raw <= 1'b1;
      @(posedge core_clk);
      step_raw <= 1'b0;
      repeat (3) begin
         @(posedge core_clk);
         if (batch_valid === 1'b1) begin
            seen = 1'b1;
            data = batch_data;
         end
      end
      if (counted) cnt = cnt + 16'h0001;
      chk_bit("batch_valid", counted, seen);
      if (counted) chk_val("batch_data", cnt, data);
   endtask : step

   initial begin
      rstn = 1'b0;
      step_raw = 1'b0;
      class_code = 8'h08;
      miscompares = 0;
      n_compared = 0;
      run1 = 0;
      last_run1 = 0;
      cnt = 16'h0000;
      codes = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D, 8'h0E, 8'h08, 8'h0B, 8'h0F, 8'h03};
      rows = '{'{8'h00, 8'h00, 1'b0, 8'h00}, '{8'h01, 8'h00, 1'b0, 8'h0A},
         '{8'h02, 8'h00, 1'b0, 8'h00}, '{8'h03, 8'h00, 1'b0, 8'h00},
         '{8'h04, 8'h00, 1'b0, 8'h00}, '{8'h05, 8'h00, 1'b0, 8'h00},
         '{8'h06, 8'h00, 1'b0, 8'h00}, '{8'h07, 8'h00, 1'b0, 8'h00},
         '{8'h08, 8'h00, 1'b0, 8'h00}, '{8'h09, 8'h00, 1'b0, 8'h00},
         '{8'h20, 8'h5A, 1'b1, 8'h00}, '{8'h06, 8'h77, 1'b1, 8'h00},
         '{8'h05, 8'h3C, 1'b1, 8'h00}, '{8'h01, 8'h03, 1'b1, 8'h03},
         '{8'h04, 8'h15, 1'b1, 8'h15}, '{8'h00, 8'h03, 1'b1, 8'h01}};
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      // Reset values, unmapped address, read-only places, then set-up
      foreach (rows[i]) begin
         if (rows[i].wr) u_host.wr(rows[i].addr, rows[i].wdata);
         rd_chk(rows[i].addr, rows[i].exp);
      end
      // Debounce of three, pulsed interrupt on int1
      step(1'b0);
      step(1'b0);
      rd_chk(8'h05, 8'h00);
      step(1'b1);
      repeat (30) @(posedge core_clk);
      chk_val("int1 pulse", TICK[15:0], last_run1[15:0]);
      rd_chk(8'h05, 8'h24);
      rd_chk(8'h05, 8'h00);
      rd_chk(8'h06, 8'h01);
      step(1'b1);
      // Short pause keeps counting, a long one rearms
      repeat (200) @(posedge core_clk);
      step(1'b1);
      repeat (30 * TICK + 40) @(posedge core_clk);
      step(1'b0);
      step(1'b0);
      step(1'b1);
      // Disable and reinit keep the count; clear zeroes it
      u_host.wr(8'h00, 8'h00);
      step(1'b0);
      rd_chk(8'h06, 8'h04);
      u_host.wr(8'h00, 8'h03);
      rd_chk(8'h06, 8'h04);
      step(1'b0);
      u_host.wr(8'h05, 8'h80);
      cnt = 16'h0000;
      rd_chk(8'h06, 8'h00);
      rd_chk(8'h07, 8'h00);
      rd_chk(8'h05, 8'h24);
      step(1'b0);
      step(1'b1);
      // Latched status, both routing bits needed, mirror clears too
      u_host.wr(8'h00, 8'h41);
      u_host.wr(8'h04, 8'h12);
      step(1'b1);
      repeat (40) @(posedge core_clk);
      chk_bit("int2", 1'b0, int2);
      chk_bit("int1", 1'b0, int1);
      rd_chk(8'h09, 8'h01);
      rd_chk(8'h08, 8'h00);
      u_host.wr(8'h04, 8'h1A);
      step(1'b1);
      repeat (40) @(posedge core_clk);
      chk_bit("int2", 1'b1, int2);
      rd_chk(8'h08, 8'h01);
      repeat (3) @(posedge core_clk);
      chk_bit("int2", 1'b0, int2);
      rd_chk(8'h09, 8'h00);
      // Classifier gate over every listed code
      u_host.wr(8'h01, 8'h01);
      u_host.wr(8'h00, 8'h0D);
      foreach (codes[i]) begin
         @(posedge core_clk);
         class_code <= codes[i];
         step(i >= 7);
      end
      u_host.wr(8'h00, 8'h15);
      @(posedge core_clk);
      class_code <= 8'h04;
      step(1'b0);
      u_host.wr(8'h00, 8'h05);
      step(1'b1);
      @(posedge core_clk);
      class_code <= 8'h08;
      // Delta window of three units
      u_host.window(16'h0003, 8'h81);
      u_host.rd(8'h05, rdv);
      step(1'b1);
      repeat (30) @(posedge core_clk);
      rd_chk(8'h05, 8'h30);
      repeat (30) @(posedge core_clk);
      rd_chk(8'h05, 8'h00);
      u_host.window(16'h0003, 8'hC1);
      u_host.rd(8'h08, rdv);
      step(1'b1);
      repeat (30) @(posedge core_clk);
      rd_chk(8'h08, 8'h01);
      u_host.window(16'h0000, 8'hC1);
      u_host.rd(8'h05, rdv);
      u_host.rd(8'h08, rdv);
      step(1'b1);
      rd_chk(8'h08, 8'h01);
      rd_chk(8'h05, 8'h24);
      // Carry mode: wrap past the top raises overflow and status
      u_host.wr(8'h00, 8'h61);
      u_host.wr(8'h05, 8'h80);
      u_host.rd(8'h05, rdv);
      u_host.rd(8'h08, rdv);
      @(posedge core_clk);
      step_raw <= 1'b1;
      repeat (65536) @(posedge core_clk);
      step_raw <= 1'b0;
      repeat (5) @(posedge core_clk);
      rd_chk(8'h06, 8'h00);
      rd_chk(8'h07, 8'h00);
      rd_chk(8'h05, 8'h2C);
      rd_chk(8'h08, 8'h01);
      final_report();
   end
endmodule : tb_top
